/* File: rtl/flq_pkg.sv */
// Constants, types and state layout for the flash command interpreter
package flq_pkg;

   // Core clock rate and self-timed erase durations
   localparam int CLK_MHZ                  = 25;
   localparam int SECTOR_ERASE_TIME_US     = 20000;
   localparam int HALF_BLOCK_ERASE_TIME_US = 100000;
   localparam int SECTOR_ERASE_CYC         = SECTOR_ERASE_TIME_US * CLK_MHZ;
   localparam int HALF_BLOCK_ERASE_CYC     = HALF_BLOCK_ERASE_TIME_US * CLK_MHZ;

   // Instruction codes
   localparam logic [7:0] CMD_WRITE_UNLOCK          = 8'h06;
   localparam logic [7:0] CMD_ENTER_QUAD            = 8'h38;
   localparam logic [7:0] CMD_EXIT_QUAD             = 8'hff;
   localparam logic [7:0] CMD_READ_PARAM            = 8'hc0;
   localparam logic [7:0] CMD_RESET                 = 8'h99;
   localparam logic [7:0] CMD_SECTOR_ERASE          = 8'h20;
   localparam logic [7:0] CMD_SECTOR_ERASE_WIDE     = 8'h21;
   localparam logic [7:0] CMD_HALF_BLOCK_ERASE      = 8'h52;
   localparam logic [7:0] CMD_HALF_BLOCK_ERASE_WIDE = 8'h5c;

   // Field positions and reset values
   localparam int         RP_FIELD_LSB     = 4;
   localparam int         LEARN_ENABLE_BIT = 7;
   localparam logic [1:0] DFIELD_RST       = 2'h0;
   localparam logic [7:0] LEARN_PATTERN    = 8'h34;
   localparam logic [2:0] ADDR_BYTES_NARROW = 3'h3;
   localparam logic [2:0] ADDR_BYTES_WIDE   = 3'h4;
   localparam logic [31:0] SECTOR_MASK     = 32'hffff_f000;
   localparam logic [31:0] HALF_BLOCK_MASK = 32'hffff_8000;
   localparam int         PROT_UNIT_LSB    = 16;
   localparam int         ARRAY_ADDR_MSB   = 25;
   localparam logic [4:0] PROT_ALL_BP      = 5'hb;
   localparam logic [10:0] PROT_UNITS      = 11'h400;

   // Dummy clocks per read-parameter field, single and double rate
   localparam logic [3:0] STR_DUMMY_TBL [0:3] = '{4'hc, 4'h6, 4'h8, 4'ha};
   localparam logic [3:0] DTR_DUMMY_TBL [0:3] = '{4'ha, 4'h8, 4'h6, 4'hc};

   // Learning pattern start offsets in dummy or mode-bit cycles
   localparam logic [3:0] LP_OFS_ONE_STR = 4'h0;
   localparam logic [3:0] LP_OFS_QUAD_OUT = 4'h2;
   localparam logic [3:0] LP_OFS_ONE_DTR = 4'h2;
   localparam logic [3:0] LP_OFS_TWO_IO  = 4'h4;
   localparam logic [3:0] LP_OFS_FOUR_IO = 4'h2;

   typedef enum logic [3:0] {
      FLQ_CMD   = 4'b0001,
      FLQ_ADDR  = 4'b0010,
      FLQ_PARAM = 4'b0100,
      FLQ_SKIP  = 4'b1000
   } flq_state_e;

   typedef enum logic [2:0] {
      RC_ONE_STR  = 3'h0,
      RC_DUAL_OUT = 3'h1,
      RC_QUAD_OUT = 3'h2,
      RC_ONE_DTR  = 3'h3,
      RC_TWO_IO   = 3'h4,
      RC_FOUR_IO  = 3'h5,
      RC_ID_SFDP  = 3'h6,
      RC_TWO_DTR  = 3'h7
   } flq_read_class_e;

   typedef struct packed {
      logic       quad_io_enable;
      logic       dummy_cycle_select;
      logic       wide_addr_mode;
      logic [4:0] block_protect_bits;
      logic [7:0] aux_config_reg;
   } flq_cfg_s;

   typedef struct packed {
      flq_read_class_e rclass;
      logic            four_io_dtr;
      logic            dummy_phase;
   } flq_read_s;

   typedef struct packed {
      logic        start;
      logic        half_block;
      logic [31:0] base;
   } flq_erase_s;

   typedef struct packed {
      logic        cs_s1;
      logic        cs_s2;
      logic        cs_d;
      logic        sclk_s1;
      logic        sclk_s2;
      logic        sclk_d;
      logic [3:0]  io_s1;
      logic [3:0]  io_s2;
      flq_state_e  st;
      logic [7:0]  sh;
      logic [3:0]  bits;
      logic [7:0]  op;
      logic [31:0] addr;
      logic [2:0]  nbytes;
      logic [2:0]  need;
      logic        extra;
      logic        quad;
      logic        wlatch;
      logic        busy;
      logic [1:0]  dfield;
      logic [31:0] timer;
      flq_erase_s  erase;
      logic        reject;
      logic [3:0]  dly;
      logic [2:0]  pidx;
      logic        drive;
      logic [3:0]  io_o;
      logic [3:0]  io_oe;
      logic [3:0]  str_d;
      logic [3:0]  dtr_d;
   } flq_state_s;

   localparam flq_state_s ST_RST = '{st: FLQ_CMD, cs_s1: 1'b1, cs_s2: 1'b1, cs_d: 1'b1,
                                     dfield: DFIELD_RST, str_d: STR_DUMMY_TBL[0],
                                     dtr_d: DTR_DUMMY_TBL[0], default: '0};

endpackage : flq_pkg

/* File: rtl/flq_flash_cmd.sv */
// Quad mode, read parameter, learning pattern and erase command handling
// Summary of operation
// R1: Quad mode read-parameter sets read dummy clocks
// R2: SPI refuses read-parameter; select bit carries into quad
// R3: Reset gives 12 single, 10 double dummies
// R4: Field 00/01/10/11 maps to dummy pairs
// R5: Aux config bit 7 enables learning pattern
// R6: Pattern follows mode bits, mode bits untouched
// R7: Pattern is fixed byte 00110100
// R8: One-line and dual reads start pattern immediately
// R9: Quad-output and double-rate one-line wait two
// R10: Two-line waits four, four-line waits two cycles
// R11: Short window cuts pattern, long window repeats
// R12: ID, security, parameter reads behave like fast read
// R13: Quad entry needs quad enable, else ignored
// R14: Exit returns SPI; latch and suspend unchanged
// R15: Host sends write unlock before erase
// R16: Erase executes only on exact byte boundary
// R17: Sector erase clears aligned 4K sector
// R18: Erase self-timed; busy flag, latch cleared after
// R19: Protected region erase is not executed
// R20: Half-block erase clears aligned 32K block
// R21: Wide variants always take 32-bit address
// R22: Erase without write latch is discarded
`timescale 1ns/1ns
module flq_flash_cmd #(
   parameter int SECTOR_ERASE_CYCLES     = flq_pkg::SECTOR_ERASE_CYC,
   parameter int HALF_BLOCK_ERASE_CYCLES = flq_pkg::HALF_BLOCK_ERASE_CYC
) (
   // Clock and reset
   input  wire logic               core_clk_in,
   input  wire logic               rstn_in,
   // Serial link pins
   input  wire logic               cs_n_in,
   input  wire logic               sclk_in,
   input  wire logic [3:0]         io_in,
   output logic [3:0]              io_out,
   output logic [3:0]              io_oe_out,
   // Configuration and read framing
   input  wire flq_pkg::flq_cfg_s  cfg_in,
   input  wire flq_pkg::flq_read_s rd_in,
   // Status
   output logic                    quad_command_mode_out,
   output logic                    write_latch_flag_out,
   output logic                    op_in_progress_flag_out,
   output logic [3:0]              str_dummy_out,
   output logic [3:0]              dtr_dummy_out,
   // Erase request to the array
   output flq_pkg::flq_erase_s     erase_out,
   output logic                    erase_reject_out
);
   import flq_pkg::*;

   flq_state_s st_r;
   flq_state_s st_nxt;

   logic       sclk_rise;
   logic       sclk_fall;
   logic       cs_rise;
   logic       selected;
   logic [7:0] shifted;
   logic [3:0] bits_inc;
   logic       byte_done;
   logic [1:0] field_eff;
   logic       lp_on;
   logic [3:0] lp_ofs;
   logic [3:0] lp_mask;
   logic       lp_dtr;
   logic       exact;

   function automatic logic is_erase(input logic [7:0] op);
      return (op == CMD_SECTOR_ERASE) || (op == CMD_SECTOR_ERASE_WIDE) ||
             (op == CMD_HALF_BLOCK_ERASE) || (op == CMD_HALF_BLOCK_ERASE_WIDE);
   endfunction

   function automatic logic is_half(input logic [7:0] op);
      return (op == CMD_HALF_BLOCK_ERASE) || (op == CMD_HALF_BLOCK_ERASE_WIDE);
   endfunction

   // Protection counts 64K units from the top of the array
   function automatic logic is_protected(input logic [31:0] a, input logic [4:0] bp);
      logic [10:0] unit;
      logic [10:0] lim;
      unit = {1'b0, a[ARRAY_ADDR_MSB:PROT_UNIT_LSB]};
      lim  = PROT_UNITS - (11'h1 << (bp - 5'h1));
      if (bp == 5'h0) begin
         return 1'b0;
      end
      if (bp >= PROT_ALL_BP) begin
         return 1'b1;
      end
      return unit >= lim;
   endfunction

   always_comb begin
      st_nxt    = st_r;
      sclk_rise = st_r.sclk_s2 & ~st_r.sclk_d;
      sclk_fall = ~st_r.sclk_s2 & st_r.sclk_d;
      cs_rise   = st_r.cs_s2 & ~st_r.cs_d;
      selected  = ~st_r.cs_s2;
      shifted   = st_r.quad ? {st_r.sh[3:0], st_r.io_s2} : {st_r.sh[6:0], st_r.io_s2[0]};
      bits_inc  = st_r.bits + (st_r.quad ? 4'h4 : 4'h1);
      byte_done = (bits_inc == 4'h8);
      exact     = (st_r.st == FLQ_ADDR) && (st_r.nbytes == st_r.need) && (st_r.bits == 4'h0);
      lp_on     = rd_in.dummy_phase & cfg_in.aux_config_reg[LEARN_ENABLE_BIT];
      lp_ofs    = LP_OFS_ONE_STR;
      lp_mask   = 4'h2;
      lp_dtr    = 1'b0;

      // Pin synchronisers
      st_nxt.cs_s1   = cs_n_in;
      st_nxt.cs_s2   = st_r.cs_s1;
      st_nxt.cs_d    = st_r.cs_s2;
      st_nxt.sclk_s1 = sclk_in;
      st_nxt.sclk_s2 = st_r.sclk_s1;
      st_nxt.sclk_d  = st_r.sclk_s2;
      st_nxt.io_s1   = io_in;
      st_nxt.io_s2   = st_r.io_s1;

      st_nxt.erase.start = 1'b0;
      st_nxt.reject      = 1'b0;

      // R18 self-timed completion
      if (st_r.busy) begin
         if (st_r.timer <= 32'h1) begin
            st_nxt.busy   = 1'b0;
            st_nxt.wlatch = 1'b0;
            st_nxt.timer = 32'h0;
         end else begin
            st_nxt.timer = st_r.timer - 32'h1;
         end
      end

      if (selected && sclk_rise) begin
         case (st_r.st)
            FLQ_CMD: begin
               st_nxt.sh   = shifted;
               st_nxt.bits = bits_inc;
               if (byte_done) begin
                  st_nxt.bits   = 4'h0;
                  st_nxt.op     = shifted;
                  st_nxt.nbytes = 3'h0;
                  st_nxt.addr   = 32'h0;
                  // R21 address width select
                  if (is_erase(shifted)) begin
                     st_nxt.st   = FLQ_ADDR;
                     st_nxt.need = ((shifted == CMD_SECTOR_ERASE_WIDE) ||
                                    (shifted == CMD_HALF_BLOCK_ERASE_WIDE) ||
                                    cfg_in.wide_addr_mode) ? ADDR_BYTES_WIDE
                                                           : ADDR_BYTES_NARROW;
                  // R2 refused outside quad mode
                  end else if ((shifted == CMD_READ_PARAM) && st_r.quad) begin
                     st_nxt.st = FLQ_PARAM;
                  end else begin
                     st_nxt.st = FLQ_SKIP;
                  end
               end
            end
            FLQ_ADDR: begin
               if (st_r.nbytes == st_r.need) begin
                  st_nxt.extra = 1'b1;
                  st_nxt.st    = FLQ_SKIP;
               end else begin
                  st_nxt.sh   = shifted;
                  st_nxt.bits = bits_inc;
                  if (byte_done) begin
                     st_nxt.bits   = 4'h0;
                     st_nxt.addr   = {st_r.addr[23:0], shifted};
                     st_nxt.nbytes = st_r.nbytes + 3'h1;
                  end
               end
            end
            FLQ_PARAM: begin
               st_nxt.sh   = shifted;
               st_nxt.bits = bits_inc;
               if (byte_done) begin
                  // R1 capture dummy field
                  st_nxt.dfield = shifted[RP_FIELD_LSB+1:RP_FIELD_LSB];
                  st_nxt.bits   = 4'h0;
                  st_nxt.st     = FLQ_SKIP;
               end
            end
            FLQ_SKIP: begin
               st_nxt.extra = 1'b1;
            end
            default: begin
               st_nxt.st = FLQ_CMD;
            end
         endcase
      end

      if (cs_rise) begin
         if ((st_r.st == FLQ_SKIP) && !st_r.extra && (st_r.bits == 4'h0)) begin
            case (st_r.op)
               CMD_WRITE_UNLOCK: begin
                  if (!st_r.busy) begin
                     st_nxt.wlatch = 1'b1;
                  end
               end
               // R13 entry gated by quad enable
               CMD_ENTER_QUAD: begin
                  if (cfg_in.quad_io_enable && !st_r.quad) begin
                     st_nxt.quad   = 1'b1;
                     st_nxt.dfield = {cfg_in.dummy_cycle_select, cfg_in.dummy_cycle_select};
                  end
               end
               // R14 exit keeps latch state
               CMD_EXIT_QUAD: begin
                  if (st_r.quad) begin
                     st_nxt.quad = 1'b0;
                  end
               end
               // R3 restore defaults
               CMD_RESET: begin
                  st_nxt.dfield = DFIELD_RST;
               end
               default: begin
                  st_nxt.op = st_r.op;
               end
            endcase
         end
         if (is_erase(st_r.op) && (st_r.st != FLQ_CMD)) begin
            // R16 boundary, R22 latch, R19 protection
            if (exact && !st_r.busy && st_r.wlatch &&
                !is_protected(st_r.addr, cfg_in.block_protect_bits)) begin
               st_nxt.busy             = 1'b1;
               st_nxt.erase.start      = 1'b1;
               st_nxt.erase.half_block = is_half(st_r.op);
               // R17 R20 aligned region
               st_nxt.erase.base = st_r.addr &
                                   (is_half(st_r.op) ? HALF_BLOCK_MASK : SECTOR_MASK);
               st_nxt.timer = is_half(st_r.op) ? 32'(HALF_BLOCK_ERASE_CYCLES)
                                               : 32'(SECTOR_ERASE_CYCLES);
            end else begin
               st_nxt.reject = 1'b1;
            end
         end
      end

      // Frame ends with chip select high
      if (!selected) begin
         st_nxt.st     = FLQ_CMD;
         st_nxt.bits   = 4'h0;
         st_nxt.nbytes = 3'h0;
         st_nxt.extra  = 1'b0;
      end

      // R2 R4 effective dummy clocks
      field_eff    = st_r.quad ? st_r.dfield
                               : {cfg_in.dummy_cycle_select, cfg_in.dummy_cycle_select};
      st_nxt.str_d = STR_DUMMY_TBL[field_eff];
      st_nxt.dtr_d = DTR_DUMMY_TBL[field_eff];

      // R8 R9 R10 R12 start offsets; mode-bit cycles count toward the offset
      case (rd_in.rclass)
         RC_ONE_STR, RC_ID_SFDP: begin
            lp_ofs = LP_OFS_ONE_STR;
         end
         RC_DUAL_OUT: begin
            lp_ofs  = LP_OFS_ONE_STR;
            lp_mask = 4'h3;
         end
         RC_QUAD_OUT: begin
            lp_ofs  = LP_OFS_QUAD_OUT;
            lp_mask = 4'hf;
         end
         RC_ONE_DTR: begin
            lp_ofs = LP_OFS_ONE_DTR;
            lp_dtr = 1'b1;
         end
         RC_TWO_IO, RC_TWO_DTR: begin
            lp_ofs  = LP_OFS_TWO_IO;
            lp_mask = 4'h3;
            lp_dtr  = (rd_in.rclass == RC_TWO_DTR);
         end
         RC_FOUR_IO: begin
            lp_ofs  = LP_OFS_FOUR_IO;
            lp_mask = 4'hf;
            lp_dtr  = rd_in.four_io_dtr;
         end
         default: begin
            lp_ofs = LP_OFS_ONE_STR;
         end
      endcase

      // R5 R6 pattern only inside the enabled dummy window
      if (!lp_on) begin
         st_nxt.drive = 1'b0;
         st_nxt.io_oe = 4'h0;
         st_nxt.io_o  = 4'h0;
         st_nxt.dly   = lp_ofs;
         st_nxt.pidx  = 3'h0;
      end else if (sclk_fall && (st_r.dly != 4'h0)) begin
         st_nxt.dly = st_r.dly - 4'h1;
      end else if (sclk_fall || (sclk_rise && st_r.drive && lp_dtr)) begin
         // R7 R11 fixed byte, wraps on overrun, cut when window closes
         st_nxt.drive = 1'b1;
         st_nxt.io_o  = {4{LEARN_PATTERN[3'h7 - st_r.pidx]}};
         st_nxt.io_oe = lp_mask;
         st_nxt.pidx  = st_r.pidx + 3'h1;
      end
   end

   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         st_r <= ST_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign io_out                  = st_r.io_o;
   assign io_oe_out               = st_r.io_oe;
   assign quad_command_mode_out   = st_r.quad;
   assign write_latch_flag_out    = st_r.wlatch;
   assign op_in_progress_flag_out = st_r.busy;
   assign str_dummy_out           = st_r.str_d;
   assign dtr_dummy_out           = st_r.dtr_d;
   assign erase_out               = st_r.erase;
   assign erase_reject_out        = st_r.reject;

   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!rstn_in);

   busy_start_a: assert property ($rose(st_r.busy) |-> st_r.erase.start) // R18
      else $error("busy flag rose without erase start");
   latch_clear_a: assert property ($fell(st_r.busy) |-> !st_r.wlatch) // R18
      else $error("write latch still set after erase");
   latch_needed_a: assert property (st_r.erase.start |-> $past(st_r.wlatch)) // R22
      else $error("erase started without write latch");
   boundary_exact_a: assert property (st_r.erase.start |-> $past(exact) && $past(cs_rise)) // R16
      else $error("erase started off byte boundary");
   protect_block_a: assert property (st_r.erase.start |-> // R19
         !is_protected(st_r.erase.base, $past(cfg_in.block_protect_bits)))
      else $error("protected region erase started");
   sector_align_a: assert property (st_r.erase.start && !st_r.erase.half_block |-> // R17
         st_r.erase.base[11:0] == 12'h0)
      else $error("sector erase base not aligned");
   half_align_a: assert property (st_r.erase.start && st_r.erase.half_block |-> // R20
         st_r.erase.base[14:0] == 15'h0)
      else $error("half-block erase base not aligned");
   quad_gate_a: assert property ($rose(st_r.quad) |-> $past(cfg_in.quad_io_enable)) // R13
      else $error("quad mode entered without quad enable");
   mode_latch_a: assert property ($changed(st_r.quad) && !$fell(st_r.busy) |-> // R14
         $stable(st_r.wlatch))
      else $error("mode switch changed write latch");
   spi_dummy_a: assert property (!st_r.quad && !cfg_in.dummy_cycle_select |=> // R2
         st_r.str_d == 4'hc && st_r.dtr_d == 4'ha)
      else $error("spi dummy clocks not from select bit");
   pattern_first_a: assert property ($rose(st_r.drive) |-> st_r.io_o == 4'h0 ##1 // R7
         (st_r.drive || !lp_on))
      else $error("learning pattern did not start with zero");
   pattern_cut_a: assert property (!lp_on |=> !st_r.drive && st_r.io_oe == 4'h0) // R11
      else $error("pattern driven outside dummy window");

endmodule // flq_flash_cmd

/* File: verification/flq_host_model.sv */
// Host controller model driving the flash pins
`timescale 1ns/1ns
module flq_host_model (
   // Clock
   input  wire logic core_clk_in,
   // Serial pins
   output logic      cs_n_out,
   output logic      sclk_out,
   output logic [3:0] io_out
);
   initial begin
      cs_n_out = 1'b1;
      sclk_out = 1'b0;
      io_out   = 4'h0;
   end
   task automatic wait_cyc(input int n);
      repeat (n) @(negedge core_clk_in);
   endtask
   // Serial clock stands still outside frames
   task automatic open_frame();
      wait_cyc(1);
      cs_n_out = 1'b0;
      wait_cyc(4);
   endtask
   // select rises right after the last unit sent
   task automatic close_frame();
      sclk_out = 1'b0;
      wait_cyc(4);
      cs_n_out = 1'b1;
      io_out   = ~io_out;
      wait_cyc(6);
   endtask
   // Units msb first; data moves while the clock is low
   task automatic frame(input logic [39:0] d, input int nbits, input logic quad);
      int i;
      open_frame();
      i = nbits;
      while (i > 0) begin
         if (quad) begin
            io_out = d[i-1 -: 4];
            i      = i - 4;
         end else begin
            io_out = {~d[i-1], ~d[i-1], ~d[i-1], d[i-1]};
            i      = i - 1;
         end
         wait_cyc(4);
         sclk_out = 1'b1;
         wait_cyc(4);
         sclk_out = 1'b0;
      end
      close_frame();
   endtask
   // Dummy window: host lets go and only clocks
   task automatic tick_high();
      io_out   = 4'h0;
      sclk_out = 1'b1;
      wait_cyc(3);
   endtask
   task automatic tick();
      wait_cyc(1);
      sclk_out = 1'b0;
      wait_cyc(4);
      sclk_out = 1'b1;
      wait_cyc(3);
   endtask
endmodule // flq_host_model

/* File: verification/tb_top.sv */
// Self-checking bench for the flash command interpreter
`timescale 1ns/1ns
module tb_top;
   import flq_pkg::*;
   localparam int SECT_CYC = 20;
   localparam int HB_CYC = 40;
   logic            core_clk_in = 1'b0;
   logic            rstn_in     = 1'b0;
   logic            cs_n, sclk;
   logic [3:0]      h_io, d_io, d_oe, io_w;
   flq_cfg_s        cfg = '0;
   flq_read_s       rd  = '{rclass: RC_ONE_STR, default: '0};
   logic            quad, latch, busy, rej;
   logic [3:0]      strd, dtrd;
   flq_erase_s      er;
   int              num_errors = 0;
   int              checked    = 0;
   int              n_start    = 0;
   int              n_rej      = 0;
   int              cyc        = 0;
   int              i;
   flq_read_class_e cls [8] = '{RC_ONE_STR, RC_DUAL_OUT, RC_QUAD_OUT, RC_ONE_DTR,
                                RC_TWO_IO, RC_TWO_DTR, RC_FOUR_IO, RC_ID_SFDP};
   int              ofs [8] = '{0, 0, 2, 2, 4, 4, 2, 0};
   logic [3:0]      lanes [8] = '{4'h2, 4'h3, 4'hf, 4'h2, 4'h3, 4'h3, 4'hf, 4'h2};
   int              sx [4] = '{12, 6, 8, 10};
   int              dx [4] = '{10, 8, 6, 12};

   always #20 core_clk_in = ~core_clk_in;
   // Lanes the device drives win over the host
   assign io_w = (d_oe & d_io) | (~d_oe & h_io);

   flq_host_model flq_host_model_inst (
      .core_clk_in (core_clk_in),
      .cs_n_out    (cs_n),
      .sclk_out    (sclk),
      .io_out      (h_io)
   );
   flq_flash_cmd #(
      .SECTOR_ERASE_CYCLES     (SECT_CYC),
      .HALF_BLOCK_ERASE_CYCLES (HB_CYC)
   ) flq_flash_cmd_inst (
      .core_clk_in             (core_clk_in),
      .rstn_in                 (rstn_in),
      .cs_n_in                 (cs_n),
      .sclk_in                 (sclk),
      .io_in                   (io_w),
      .io_out                  (d_io),
      .io_oe_out               (d_oe),
      .cfg_in                  (cfg),
      .rd_in                   (rd),
      .quad_command_mode_out   (quad),
      .write_latch_flag_out    (latch),
      .op_in_progress_flag_out (busy),
      .str_dummy_out           (strd),
      .dtr_dummy_out           (dtrd),
      .erase_out               (er),
      .erase_reject_out        (rej)
   );

   task automatic end_sim();
      $display("Checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Pulses are one cycle wide, so count them as they pass
   always @(posedge core_clk_in) begin
      cyc <= cyc + 1;
      if (er.start === 1'b1) n_start <= n_start + 1;
      if (rej === 1'b1) n_rej <= n_rej + 1;
      if (cyc == 20000) begin
         num_errors = num_errors + 1;
         end_sim();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc_wait(input int n);
      repeat (n) @(negedge core_clk_in);
   endtask
   task automatic send(input logic [39:0] d, input int n, input logic q);
      flq_host_model_inst.frame(d, n, q);
   endtask

   // One erase frame; either a start pulse or a reject pulse
   task automatic erase(input logic [39:0] d, input int n, input logic go,
                        input logic [31:0] base, input logic hb, input int dur);
      int s0, r0;
      s0 = n_start;
      r0 = n_rej;
      send(d, n, 1'b0);
      chk(n_start - s0, go);
      chk(n_rej - r0, !go);
      if (go) begin
         chk(er.base, base);
         chk(er.half_block, hb);
         chk(busy, 1);
         cyc_wait(dur + 10);
         chk(latch, 0);
      end
      chk(busy, 0);
   endtask

   // Dummy window of a read with the pattern on or off
   task automatic lp(input flq_read_class_e c, input int o, input logic [3:0] ln,
                     input logic en);
      int k;
      int n;
      rd.rclass                 = c;
      cfg.aux_config_reg[7]     = en;
      flq_host_model_inst.open_frame();
      flq_host_model_inst.tick_high();
      rd.dummy_phase = 1'b1;
      for (k = 1; k <= 12; k++) begin
         flq_host_model_inst.tick();
         // Double-rate classes move one pattern bit on each serial clock edge
         n = (c == RC_ONE_DTR || c == RC_TWO_DTR) ? 2 * (k - o) - 1 : k - 1 - o;
         if (k > o) begin
            chk(d_oe, en ? ln : 4'h0);
            if (en) chk(d_io[1], LEARN_PATTERN[7 - (n % 8)]);
         end else begin
            chk(d_oe, 4'h0);
         end
      end
      rd.dummy_phase = 1'b0;
      cyc_wait(2);
      chk(d_oe, 4'h0);
      flq_host_model_inst.close_frame();
   endtask

   initial begin
      cyc_wait(8);
      rstn_in = 1'b1;
      cyc_wait(4);
      chk(strd, 12);
      chk(dtrd, 10);
      chk(quad, 0);
      lp(RC_ONE_STR, 0, 4'h2, 1'b0);
      for (i = 0; i < 8; i++) lp(cls[i], ofs[i], lanes[i], 1'b1);
      cfg.dummy_cycle_select = 1'b1;
      cyc_wait(2);
      chk(strd, 10);
      send(40'hc030, 16, 1'b0);
      chk(dtrd, 12);
      send(40'h38, 8, 1'b0);
      chk(quad, 0);
      cfg.quad_io_enable = 1'b1;
      send(40'h38, 8, 1'b0);
      chk(quad, 1);
      chk(strd, 10);
      for (i = 0; i < 4; i++) begin
         send({24'h0, 8'hc0, 2'h0, 2'(i), 4'h0}, 16, 1'b1);
         chk(strd, sx[i]);
         chk(dtrd, dx[i]);
      end
      send(40'h99, 8, 1'b1);
      chk(strd, 12);
      // write unlock ahead of every erase except the repeated sector erase, which is refused
      send(40'h06, 8, 1'b1);
      chk(latch, 1);
      send(40'hff, 8, 1'b1);
      chk(quad, 0);
      chk(latch, 1);
      erase(40'h20123456, 32, 1'b1, 32'h00123000, 1'b0, SECT_CYC);
      erase(40'h20123456, 32, 1'b0, 32'h0, 1'b0, 0);
      send(40'h06, 8, 1'b0);
      erase(40'h10091a2b, 31, 1'b0, 32'h0, 1'b0, 0);
      send(40'h06, 8, 1'b0);
      erase(40'h5200abcd, 32, 1'b1, 32'h00008000, 1'b1, HB_CYC);
      send(40'h06, 8, 1'b0);
      erase(40'h2101234567, 40, 1'b1, 32'h01234000, 1'b0, SECT_CYC);
      send(40'h06, 8, 1'b0);
      erase(40'h5c00009abc, 40, 1'b1, 32'h00008000, 1'b1, HB_CYC);
      // Four-byte address mode widens the base sector erase too
      cfg.wide_addr_mode = 1'b1;
      send(40'h06, 8, 1'b0);
      erase(40'h2001234567, 40, 1'b1, 32'h01234000, 1'b0, SECT_CYC);
      cfg.wide_addr_mode = 1'b0;
      cfg.block_protect_bits = 5'h1;
      send(40'h06, 8, 1'b0);
      erase(40'h2103ff1000, 40, 1'b0, 32'h0, 1'b0, 0);
      end_sim();
   end
endmodule // tb_top
